// ===== shared/pnpp_pkg.sv
// Purpose: Constants for the parallel nonvolatile programming port.
// Assumes: All pins are synchronous to the core clock.
// Notes:   Fuse and lock reset values stand in for the stored state.
`default_nettype none

package pnpp_pkg;

  // ************************************************************
  // Command bytes
  // ************************************************************
  localparam logic [7:0] CMD_NOP      = 8'h00;
  localparam logic [7:0] CMD_WR_FUSE  = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK  = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EEP   = 8'h11;
  localparam logic [7:0] CMD_RD_SIG   = 8'h08;
  localparam logic [7:0] CMD_RD_FL    = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EEP   = 8'h03;

  // ************************************************************
  // Action select codes and byte select pairs
  // ************************************************************
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD  = 2'h2;
  localparam logic [1:0] ACT_IDLE = 2'h3;

  // Pairs are {secondary, primary}.
  localparam logic [1:0] SEL_FUSE_LOW  = 2'h0;
  localparam logic [1:0] SEL_LOCK      = 2'h1;
  localparam logic [1:0] SEL_FUSE_EXT  = 2'h2;
  localparam logic [1:0] SEL_FUSE_HIGH = 2'h3;

  // ************************************************************
  // Reset values and lock fields
  // ************************************************************
  localparam logic [7:0] FUSE_LOW_RST  = 8'hFF;
  localparam logic [7:0] FUSE_HIGH_RST = 8'hFF;
  localparam logic [7:0] FUSE_EXT_RST  = 8'hFF;
  localparam logic [7:0] LOCK_RST      = 8'hFF;
  localparam int         LOCK_ONE_BIT  = 0;
  localparam int         LOCK_TWO_BIT  = 1;
  localparam logic [7:0] BOOT_LOCK_MSK = 8'h3C;

  // ************************************************************
  // Geometry and timing
  // ************************************************************
  localparam int FLASH_ADDR_BITS = 13;
  localparam int FLASH_PAGE_BITS = 6;
  localparam int EEP_ADDR_BITS   = 9;
  localparam int EEP_PAGE_BITS   = 2;
  localparam int PROG_BUSY_CYC   = 128;

endpackage

`default_nettype wire

// ===== src/pnpp_port.sv
// Purpose: Parallel programming port for flash, EEPROM, fuses and locks.
// Assumes: Strobes are synchronous and held for at least one clock.
// Notes:   Chip erase is not served here, so locks only clear at reset.
`timescale 1ns/100ps
`default_nettype none

module pnpp_port
  import pnpp_pkg::*;
#(
  parameter int         FLASH_ADDR_W = FLASH_ADDR_BITS,
  parameter int         FLASH_PAGE_W = FLASH_PAGE_BITS,
  parameter int         EEP_ADDR_W   = EEP_ADDR_BITS,
  parameter int         EEP_PAGE_W   = EEP_PAGE_BITS,
  parameter int         BUSY_CYCLES  = PROG_BUSY_CYC,
  // Identity values below are arbitrary.
  parameter logic [7:0] SIG_BYTE0    = 8'h5A,
  parameter logic [7:0] SIG_BYTE1    = 8'h01,
  parameter logic [7:0] SIG_BYTE2    = 8'h02,
  parameter logic [7:0] CAL_BYTE     = 8'h80
) (
  input  wire logic       CLOCK_I,
  input  wire logic       SYS_RST_I,
  input  wire logic       LOAD_STROBE_I,
  input  wire logic       ACTION_SELECT_HIGH_I,
  input  wire logic       ACTION_SELECT_LOW_I,
  input  wire logic       BYTE_SELECT_PRIMARY_I,
  input  wire logic       BYTE_SELECT_SECONDARY_I,
  input  wire logic       PAGE_LATCH_STROBE_I,
  input  wire logic       WRITE_N_I,
  input  wire logic       OUTPUT_EN_N_I,
  input  wire logic [7:0] DATA_I,
  output var  logic [7:0] DATA_O,
  output var  logic       DATA_OE_O,
  output var  logic       READY_FLAG_O
);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  if (FLASH_ADDR_W < 9 || FLASH_ADDR_W > 16 || FLASH_PAGE_W > 8 ||
      EEP_ADDR_W < 9 || EEP_ADDR_W > 16 || EEP_PAGE_W > 8 ||
      BUSY_CYCLES < (1 << FLASH_PAGE_W) || BUSY_CYCLES < (1 << EEP_PAGE_W)) begin : g_bad
    $error("pnpp_port: unsupported geometry or busy time");
  end

  localparam int CNT_W = $clog2(BUSY_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(BUSY_CYCLES - 1);
  localparam logic [CNT_W-1:0] FL_WORDS = CNT_W'(1 << FLASH_PAGE_W);
  localparam logic [CNT_W-1:0] EE_BYTES = CNT_W'(1 << EEP_PAGE_W);

  typedef enum logic {ST_IDLE, ST_PROG} pnpp_state_t;

  // ************************************************************
  // State
  // ************************************************************
  pnpp_state_t      state_ff, nxt_state;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [7:0]       cmd_ff, nxt_cmd;
  logic [7:0]       addr_lo_ff, nxt_addr_lo;
  logic [7:0]       addr_hi_ff, nxt_addr_hi;
  logic [7:0]       data_lo_ff, nxt_data_lo;
  logic [7:0]       data_hi_ff, nxt_data_hi;
  logic [7:0]       fuse_lo_ff, nxt_fuse_lo;
  logic [7:0]       fuse_hi_ff, nxt_fuse_hi;
  logic [7:0]       fuse_ex_ff, nxt_fuse_ex;
  logic [7:0]       lock_ff, nxt_lock;
  logic             load_q_ff, latch_q_ff, wr_q_ff;
  logic [7:0]       data_out_ff, nxt_data_out;
  logic             data_oe_ff, ready_ff;

  logic [15:0]      flash_mem [0:(1<<FLASH_ADDR_W)-1];
  logic [7:0]       eep_mem   [0:(1<<EEP_ADDR_W)-1];
  logic [15:0]      fbuf      [0:(1<<FLASH_PAGE_W)-1];
  logic [7:0]       ebuf      [0:(1<<EEP_PAGE_W)-1];

  logic [15:0]             addr_full;
  logic [FLASH_ADDR_W-1:0] fl_addr, fl_wr_addr;
  logic [EEP_ADDR_W-1:0]   ee_addr, ee_wr_addr;
  logic [1:0]              act, sel;
  logic                    idle, load_go, latch_go, wr_go;
  logic                    fl_we, ee_we, mode3;

  assign addr_full = {addr_hi_ff, addr_lo_ff};
  assign fl_addr   = addr_full[FLASH_ADDR_W-1:0];
  assign ee_addr   = addr_full[EEP_ADDR_W-1:0];
  assign act       = {ACTION_SELECT_HIGH_I, ACTION_SELECT_LOW_I};
  assign sel       = {BYTE_SELECT_SECONDARY_I, BYTE_SELECT_PRIMARY_I};
  assign idle      = (state_ff == ST_IDLE);
  // Strobes are refused while busy so the page in flight cannot be disturbed.
  assign load_go   = idle && LOAD_STROBE_I && !load_q_ff;
  assign latch_go  = idle && PAGE_LATCH_STROBE_I && !latch_q_ff;
  assign wr_go     = idle && !WRITE_N_I && wr_q_ff;
  assign mode3     = !lock_ff[LOCK_ONE_BIT] && !lock_ff[LOCK_TWO_BIT];

  // The page part of the address includes the top bits of the low byte.
  assign fl_wr_addr = {fl_addr[FLASH_ADDR_W-1:FLASH_PAGE_W], cnt_ff[FLASH_PAGE_W-1:0]};
  assign ee_wr_addr = {ee_addr[EEP_ADDR_W-1:EEP_PAGE_W], cnt_ff[EEP_PAGE_W-1:0]};
  assign fl_we = !idle && (cmd_ff == CMD_WR_FLASH) && (cnt_ff < FL_WORDS);
  assign ee_we = !idle && (cmd_ff == CMD_WR_EEP) && (cnt_ff < EE_BYTES);

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    nxt_state   = state_ff;
    nxt_cnt     = cnt_ff;
    nxt_cmd     = cmd_ff;
    nxt_addr_lo = addr_lo_ff;
    nxt_addr_hi = addr_hi_ff;
    nxt_data_lo = data_lo_ff;
    nxt_data_hi = data_hi_ff;
    nxt_fuse_lo = fuse_lo_ff;
    nxt_fuse_hi = fuse_hi_ff;
    nxt_fuse_ex = fuse_ex_ff;
    nxt_lock    = lock_ff;
    if (load_go) begin
      case (act)
        ACT_CMD: begin
          // Loading the no-operation byte also drops any write mode.
          nxt_cmd = DATA_I;
        end
        ACT_ADDR: begin
          if (BYTE_SELECT_PRIMARY_I) begin
            nxt_addr_hi = DATA_I;
          end else begin
            nxt_addr_lo = DATA_I;
          end
        end
        ACT_DATA: begin
          if (BYTE_SELECT_PRIMARY_I) begin
            nxt_data_hi = DATA_I;
          end else begin
            nxt_data_lo = DATA_I;
          end
        end
        default: begin
          nxt_cmd = cmd_ff;
        end
      endcase
    end
    case (state_ff)
      ST_IDLE: begin
        if (wr_go) begin
          case (cmd_ff)
            CMD_WR_FLASH, CMD_WR_EEP: begin
              nxt_state = ST_PROG;
            end
            CMD_WR_FUSE: begin
              nxt_state = ST_PROG;
              case (sel)
                SEL_FUSE_LOW:  nxt_fuse_lo = data_lo_ff;
                SEL_LOCK:      nxt_fuse_hi = data_lo_ff;
                SEL_FUSE_EXT:  nxt_fuse_ex = data_lo_ff;
                default:       nxt_fuse_lo = fuse_lo_ff;
              endcase
            end
            CMD_WR_LOCK: begin
              nxt_state = ST_PROG;
              // A write can only clear bits; erasing needs a chip erase.
              nxt_lock = lock_ff & data_lo_ff;
              if (mode3) begin
                nxt_lock = (nxt_lock & ~BOOT_LOCK_MSK) | (lock_ff & BOOT_LOCK_MSK);
              end
            end
            default: begin
              nxt_state = ST_IDLE;
            end
          endcase
          nxt_cnt = '0;
        end
      end
      ST_PROG: begin
        nxt_cnt = cnt_ff + CNT_W'(1);
        if (cnt_ff == CNT_LAST) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // ************************************************************
  // Read data path
  // ************************************************************
  always_comb begin
    nxt_data_out = 8'h00;
    if (!OUTPUT_EN_N_I) begin
      case (cmd_ff)
        CMD_RD_FLASH: begin
          nxt_data_out = BYTE_SELECT_PRIMARY_I ? flash_mem[fl_addr][15:8] : flash_mem[fl_addr][7:0];
        end
        CMD_RD_EEP: begin
          if (!BYTE_SELECT_PRIMARY_I) begin
            nxt_data_out = eep_mem[ee_addr];
          end
        end
        CMD_RD_FL: begin
          case (sel)
            SEL_FUSE_LOW:  nxt_data_out = fuse_lo_ff;
            SEL_FUSE_HIGH: nxt_data_out = fuse_hi_ff;
            SEL_FUSE_EXT:  nxt_data_out = fuse_ex_ff;
            default:       nxt_data_out = lock_ff;
          endcase
        end
        CMD_RD_SIG: begin
          if (BYTE_SELECT_PRIMARY_I) begin
            if (addr_lo_ff == 8'h00) begin
              nxt_data_out = CAL_BYTE;
            end
          end else begin
            case (addr_lo_ff)
              8'h00:   nxt_data_out = SIG_BYTE0;
              8'h01:   nxt_data_out = SIG_BYTE1;
              8'h02:   nxt_data_out = SIG_BYTE2;
              default: nxt_data_out = 8'h00;
            endcase
          end
        end
        default: begin
          nxt_data_out = 8'h00;
        end
      endcase
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      state_ff    <= ST_IDLE;
      cnt_ff      <= '0;
      cmd_ff      <= CMD_NOP;
      addr_lo_ff  <= 8'h00;
      addr_hi_ff  <= 8'h00;
      data_lo_ff  <= 8'h00;
      data_hi_ff  <= 8'h00;
      fuse_lo_ff  <= FUSE_LOW_RST;
      fuse_hi_ff  <= FUSE_HIGH_RST;
      fuse_ex_ff  <= FUSE_EXT_RST;
      lock_ff     <= LOCK_RST;
      load_q_ff   <= 1'b0;
      latch_q_ff  <= 1'b0;
      wr_q_ff     <= 1'b1;
      data_out_ff <= 8'h00;
      data_oe_ff  <= 1'b0;
      ready_ff    <= 1'b1;
    end else begin
      state_ff    <= nxt_state;
      cnt_ff      <= nxt_cnt;
      cmd_ff      <= nxt_cmd;
      addr_lo_ff  <= nxt_addr_lo;
      addr_hi_ff  <= nxt_addr_hi;
      data_lo_ff  <= nxt_data_lo;
      data_hi_ff  <= nxt_data_hi;
      fuse_lo_ff  <= nxt_fuse_lo;
      fuse_hi_ff  <= nxt_fuse_hi;
      fuse_ex_ff  <= nxt_fuse_ex;
      lock_ff     <= nxt_lock;
      load_q_ff   <= LOAD_STROBE_I;
      latch_q_ff  <= PAGE_LATCH_STROBE_I;
      wr_q_ff     <= WRITE_N_I;
      data_out_ff <= nxt_data_out;
      data_oe_ff  <= !OUTPUT_EN_N_I;
      ready_ff    <= (nxt_state == ST_IDLE);
    end
  end

  // Arrays hold no reset; their content models stored cells.
  always_ff @(posedge CLOCK_I) begin
    if (latch_go && (cmd_ff == CMD_WR_FLASH) && BYTE_SELECT_PRIMARY_I) begin
      fbuf[addr_lo_ff[FLASH_PAGE_W-1:0]] <= {data_hi_ff, data_lo_ff};
    end
    if (latch_go && (cmd_ff == CMD_WR_EEP)) begin
      ebuf[addr_lo_ff[EEP_PAGE_W-1:0]] <= data_lo_ff;
    end
    if (fl_we) begin
      flash_mem[fl_wr_addr] <= fbuf[cnt_ff[FLASH_PAGE_W-1:0]];
    end
    if (ee_we) begin
      eep_mem[ee_wr_addr] <= ebuf[cnt_ff[EEP_PAGE_W-1:0]];
    end
  end

  assign DATA_O       = data_out_ff;
  assign DATA_OE_O    = data_oe_ff;
  assign READY_FLAG_O = ready_ff;

  // ************************************************************
  // Assertions
  // ************************************************************
  a_write_busy: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    (wr_go && cmd_ff == CMD_WR_FLASH) |=> !READY_FLAG_O [*8])
    else $error("ready not low after page write");
  a_ready_return: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    wr_go |-> ##[1:1000] READY_FLAG_O)
    else $error("ready never returned");
  a_cmd_load: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    (load_go && act == ACT_CMD) |=> cmd_ff == $past(DATA_I))
    else $error("command not captured");
  a_addr_low: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    (load_go && act == ACT_ADDR && !BYTE_SELECT_PRIMARY_I) |=> addr_lo_ff == $past(DATA_I) && $stable(addr_hi_ff))
    else $error("low address not captured");
  a_addr_high: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    (load_go && act == ACT_ADDR && BYTE_SELECT_PRIMARY_I) |=> addr_hi_ff == $past(DATA_I) && $stable(addr_lo_ff))
    else $error("high address not captured");
  a_idle_load: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    (load_go && act == ACT_IDLE) |=> $stable(cmd_ff) && $stable(addr_lo_ff) && $stable(data_lo_ff))
    else $error("idle action changed state");
  a_bus_release: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    OUTPUT_EN_N_I |=> !DATA_OE_O && DATA_O == 8'h00)
    else $error("bus driven with enable high");
  a_lock_monotone: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    !$past(SYS_RST_I) |-> (lock_ff & ~$past(lock_ff)) == 8'h00)
    else $error("lock bit returned unprogrammed");
  a_boot_guard: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    (wr_go && cmd_ff == CMD_WR_LOCK && mode3) |=> (lock_ff & BOOT_LOCK_MSK) == ($past(lock_ff) & BOOT_LOCK_MSK))
    else $error("boot lock programmed in mode three");
  a_sig_read: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    (!OUTPUT_EN_N_I && cmd_ff == CMD_RD_SIG && !BYTE_SELECT_PRIMARY_I && addr_lo_ff == 8'h01)
      |=> DATA_OE_O && DATA_O == SIG_BYTE1)
    else $error("signature byte wrong");

endmodule

`default_nettype wire

// ===== verification/pnpp_prog.sv
// Purpose: Behavioural model of the external programmer driving the port pins.
// Assumes: One clock; every pin changes just after a rising edge.
// Notes:   ld, latch and wr hold selects one cycle before and during the strobe; rd sets them with oe_n.
`timescale 1ns/100ps
`default_nettype none

module pnpp_prog (
  input  wire logic       clk_i,
  input  wire logic [7:0] q_i,
  input  wire logic       q_oe_i,
  output var  logic       ld_o,
  output var  logic [1:0] act_o,
  output var  logic       bs1_o,
  output var  logic       bs2_o,
  output var  logic       pl_o,
  output var  logic       wr_n_o,
  output var  logic       oe_n_o,
  output var  logic [7:0] d_o
);
  initial begin
    ld_o   = 1'b0;
    act_o  = 2'h3;
    bs1_o  = 1'b0;
    bs2_o  = 1'b0;
    pl_o   = 1'b0;
    wr_n_o = 1'b1;
    oe_n_o = 1'b1;
    d_o    = 8'h00;
  end

  // Action code {high,low} picks command, address or data.
  task automatic ld(input logic [1:0] a, input logic b1, input logic [7:0] d);
    @(posedge clk_i);
    act_o <= a;
    bs1_o <= b1;
    d_o   <= d;
    @(posedge clk_i);
    ld_o <= 1'b1;
    @(posedge clk_i);
    ld_o <= 1'b0;
  endtask

  // Primary select is raised before the latch pulse.
  task automatic latch();
    @(posedge clk_i);
    bs1_o <= 1'b1;
    @(posedge clk_i);
    pl_o <= 1'b1;
    @(posedge clk_i);
    pl_o <= 1'b0;
  endtask

  // Negative write pulse with the target selects held.
  task automatic wr(input logic b1, input logic b2);
    @(posedge clk_i);
    bs1_o <= b1;
    bs2_o <= b2;
    @(posedge clk_i);
    wr_n_o <= 1'b0;
    @(posedge clk_i);
    wr_n_o <= 1'b1;
  endtask

  // The bus is released while reading; the inverse shows a stale value up.
  task automatic rd(input logic b1, input logic b2, output logic [7:0] q, output logic oe);
    @(posedge clk_i);
    oe_n_o <= 1'b0;
    bs1_o  <= b1;
    bs2_o  <= b2;
    d_o    <= ~d_o;
    @(posedge clk_i);
    @(posedge clk_i);
    #1;
    q  = q_i;
    oe = q_oe_i;
    @(posedge clk_i);
    oe_n_o <= 1'b1;
  endtask
endmodule

`default_nettype wire

// ===== verification/pnpp_port_tb.sv
// Purpose: Self-checking bench for the parallel programming port.
// Assumes: Busy time shortened to 64 cycles.
// Notes:   Memory arrays start unknown, so only written words are read.
`timescale 1ns/100ps
`default_nettype none

module pnpp_port_tb;
  import pnpp_pkg::*;
  localparam int         BUSY = 64;
  // Identity values are arbitrary.
  localparam logic [7:0] SIG0 = 8'h5A;
  localparam logic [7:0] SIG1 = 8'h01;
  localparam logic [7:0] SIG2 = 8'h02;
  localparam logic [7:0] CAL  = 8'h80;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       ld, bs1, bs2, pl, wr_n, oe_n, data_oe, rdy;
  logic [1:0] act;
  logic [7:0] pd, dout;
  wire  [7:0] bus_w = data_oe ? dout : pd;
  int         num_errors = 0;
  int         checks = 0;
  int         cyc = 0;

  always #4 clk = ~clk;

  pnpp_prog prg (.clk_i(clk), .q_i(bus_w), .q_oe_i(data_oe), .ld_o(ld), .act_o(act), .bs1_o(bs1),
    .bs2_o(bs2), .pl_o(pl), .wr_n_o(wr_n), .oe_n_o(oe_n), .d_o(pd));

  pnpp_port #(.BUSY_CYCLES(BUSY), .SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2),
    .CAL_BYTE(CAL)) dut (.CLOCK_I(clk), .SYS_RST_I(rst), .LOAD_STROBE_I(ld),
    .ACTION_SELECT_HIGH_I(act[1]), .ACTION_SELECT_LOW_I(act[0]), .BYTE_SELECT_PRIMARY_I(bs1),
    .BYTE_SELECT_SECONDARY_I(bs2), .PAGE_LATCH_STROBE_I(pl), .WRITE_N_I(wr_n),
    .OUTPUT_EN_N_I(oe_n), .DATA_I(bus_w), .DATA_O(dout), .DATA_OE_O(data_oe), .READY_FLAG_O(rdy));

  // ************************************************************
  // Shared checks
  // ************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic wrap_up();
    if (num_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  // Busy must last exactly the configured count when a write starts.
  // Ready falls at the edge that takes the strobe, which is the edge at which the
  // write task returns, so sampling starts one busy cycle late and counts one less.
  task automatic wait_ready(input logic busy);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    chk({7'h0, rdy}, {7'h0, ~busy}, "ready after write");
    while (rdy !== 1'b1 && n < BUSY + 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(8'(n), busy ? 8'(BUSY - 1) : 8'h00, "busy length");
  endtask

  task automatic rd_chk(input logic b1, input logic b2, input logic [7:0] exp);
    logic [7:0] q;
    logic       oe;
    prg.rd(b1, b2, q, oe);
    chk(q, exp, "read byte");
    chk({7'h0, oe}, 8'h01, "bus driven");
    @(posedge clk);
    #1;
    chk({7'h0, data_oe}, 8'h00, "bus released");
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    chk({7'h0, rdy}, 8'h01, "ready at reset");
    prg.ld(ACT_CMD, 1'b0, CMD_RD_FL);
    rd_chk(1'b0, 1'b0, FUSE_LOW_RST);
    rd_chk(1'b1, 1'b1, FUSE_HIGH_RST);
    rd_chk(1'b0, 1'b1, FUSE_EXT_RST);
    rd_chk(1'b1, 1'b0, LOCK_RST);
  endtask

  // Two boundary words of a page whose number uses the low byte's top bits.
  task automatic t_flash();
    prg.ld(ACT_CMD, 1'b0, CMD_WR_FLASH);
    for (int i = 0; i < 2; i++) begin
      prg.ld(ACT_ADDR, 1'b0, i ? 8'hFF : 8'hC0);
      prg.ld(ACT_DATA, 1'b0, 8'h11 + 8'(i));
      prg.ld(ACT_DATA, 1'b1, 8'hE0 + 8'(i));
      prg.latch();
    end
    prg.ld(ACT_ADDR, 1'b1, 8'h01);
    prg.wr(1'b0, 1'b0);
    wait_ready(1'b1);
    prg.ld(ACT_CMD, 1'b0, CMD_RD_FLASH);
    for (int i = 0; i < 2; i++) begin
      prg.ld(ACT_ADDR, 1'b0, i ? 8'hFF : 8'hC0);
      rd_chk(1'b0, 1'b0, 8'h11 + 8'(i));
      rd_chk(1'b1, 1'b0, 8'hE0 + 8'(i));
    end
    prg.ld(ACT_CMD, 1'b0, CMD_NOP);
    prg.wr(1'b0, 1'b0);
    wait_ready(1'b0);
  endtask

  task automatic t_eep();
    prg.ld(ACT_CMD, 1'b0, CMD_WR_EEP);
    prg.ld(ACT_ADDR, 1'b1, 8'h01);
    for (int i = 0; i < 2; i++) begin
      prg.ld(ACT_ADDR, 1'b0, 8'h02 + 8'(i));
      prg.ld(ACT_DATA, 1'b0, 8'h5C ^ 8'(i));
      prg.latch();
    end
    prg.wr(1'b0, 1'b0);
    wait_ready(1'b1);
    prg.ld(ACT_CMD, 1'b0, CMD_RD_EEP);
    for (int i = 0; i < 2; i++) begin
      prg.ld(ACT_ADDR, 1'b0, 8'h02 + 8'(i));
      rd_chk(1'b0, 1'b0, 8'h5C ^ 8'(i));
    end
  endtask

  task automatic t_fuse();
    prg.ld(ACT_CMD, 1'b0, CMD_WR_FUSE);
    for (int i = 0; i < 3; i++) begin
      prg.ld(ACT_DATA, 1'b0, 8'hA1 + 8'(i));
      prg.wr(i == 1, i == 2);
      wait_ready(1'b1);
    end
    prg.ld(ACT_CMD, 1'b0, CMD_RD_FL);
    rd_chk(1'b0, 1'b0, 8'hA1);
    rd_chk(1'b1, 1'b1, 8'hA2);
    rd_chk(1'b0, 1'b1, 8'hA3);
  endtask

  // Mode three first, then try to clear boot bits, then try to raise all bits.
  task automatic t_lock();
    logic [7:0] lk;
    logic [7:0] d;
    lk = LOCK_RST;
    for (int i = 0; i < 3; i++) begin
      d = (i == 0) ? 8'hFC : (i == 1) ? 8'hC3 : 8'hFF;
      prg.ld(ACT_CMD, 1'b0, CMD_WR_LOCK);
      prg.ld(ACT_DATA, 1'b0, d);
      prg.wr(1'b0, 1'b0);
      wait_ready(1'b1);
      if (!lk[LOCK_ONE_BIT] && !lk[LOCK_TWO_BIT]) begin
        d = d | BOOT_LOCK_MSK;
      end
      lk = lk & d;
      prg.ld(ACT_CMD, 1'b0, CMD_RD_FL);
      rd_chk(1'b1, 1'b0, lk);
    end
  endtask

  task automatic t_sig();
    prg.ld(ACT_CMD, 1'b0, CMD_RD_SIG);
    for (int i = 0; i < 3; i++) begin
      prg.ld(ACT_ADDR, 1'b0, 8'(i));
      rd_chk(1'b0, 1'b0, (i == 0) ? SIG0 : (i == 1) ? SIG1 : SIG2);
    end
    prg.ld(ACT_ADDR, 1'b0, 8'h00);
    prg.ld(ACT_IDLE, 1'b0, 8'h02);
    rd_chk(1'b1, 1'b0, CAL);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_flash();
    t_eep();
    t_fuse();
    t_lock();
    t_sig();
    wrap_up();
  end
endmodule

`default_nettype wire
